// >>> design/lpsc_top.sv
// low-power state control: power state machine and its ahb-lite registers
//
// Functional notes
// - line energy is watched only while the detect enable bit is one.
// - sleep is entered only while the sleep permission bit is one.
// - at power-up the autonomous bit picks normal (1) or standby (0).
// - a one in the standby command bit enters standby; bit self-clears.
// - a one in the normal command bit enters normal unless the standby bit is also one; bit self-clears.
// - status bits 6..0 report 0x2 in standby and 0x4 in normal.
`default_nettype none

module lpsc_top
	import lpsc_pkg::*;
(
	input  wire logic        CLK_IN,          // 20 mhz clock
	input  wire logic        RST_N_IN,        // synchronous reset, active low
	input  wire logic        HSEL_IN,         // ahb slave select
	input  wire logic [31:0] HADDR_IN,        // ahb byte address
	input  wire logic [1:0]  HTRANS_IN,       // ahb transfer type
	input  wire logic        HWRITE_IN,       // ahb write
	input  wire logic [2:0]  HSIZE_IN,        // ahb size, word only
	input  wire logic [31:0] HWDATA_IN,       // ahb write data
	input  wire logic        HREADY_IN,       // ahb bus ready
	input  wire logic        AUTO_STRAP_IN,   // autonomous mode strap pin
	input  wire logic        ENERGY_IN,       // raw line energy indication
	input  wire logic        SLEEP_REQ_IN,    // sleep request from line side
	output logic      [31:0] HRDATA_OUT,      // ahb read data
	output logic             HREADYOUT_OUT,   // ahb slave ready
	output logic             HRESP_OUT,       // ahb response, always okay
	output logic      [6:0]  PWR_STATE_OUT,   // current power state code
	output logic             SLEEP_OUT,       // device is asleep
	output logic             ED_ENABLE_OUT,   // energy detector powered
	output logic             ENERGY_SEEN_OUT  // gated energy indication
);

	// -------------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------------
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic       strap_s;
	logic       energy_s;
	logic       sleep_req_s;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {AUTO_STRAP_IN, ENERGY_IN, SLEEP_REQ_IN};
			sync2_q <= sync1_q;
		end
	end

	assign strap_s     = sync2_q[2];
	assign energy_s    = sync2_q[1];
	assign sleep_req_s = sync2_q[0];

	// -------------------------------------------------------------------
	// ahb-lite address phase
	// -------------------------------------------------------------------
	logic        addr_valid;
	logic        wr_pend_q;
	logic        wr_pend_d;
	logic [31:0] wr_addr_q;
	logic [31:0] wr_addr_d;
	logic        wr_feature;
	logic        wr_command;

	assign addr_valid = HSEL_IN && HREADY_IN &&
	                    (HTRANS_IN == LPSC_HTRANS_NONSEQ);
	assign wr_feature = wr_pend_q && (wr_addr_q == LPSC_ADDR_FEATURE);
	assign wr_command = wr_pend_q && (wr_addr_q == LPSC_ADDR_COMMAND);

	always_comb begin
		wr_pend_d = addr_valid && HWRITE_IN;
		wr_addr_d = wr_addr_q;
		if (addr_valid) begin
			wr_addr_d = HADDR_IN;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h00000000;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
		end
	end

	// -------------------------------------------------------------------
	// configuration, command and power state
	// -------------------------------------------------------------------
	lpsc_state_t state_q;
	lpsc_state_t state_d;
	logic [15:0] cfg_q;
	logic [15:0] cfg_d;
	logic [15:0] cmd_q;
	logic [15:0] cmd_d;
	logic [1:0]  settle_q;
	logic [1:0]  settle_d;
	logic [6:0]  code_d;
	logic        seen_d;

	always_comb begin
		state_d  = state_q;
		cfg_d    = cfg_q;
		cmd_d    = cmd_q;
		settle_d = settle_q;
		// software feature writes first; hardware updates below take priority over them
		if (wr_feature) begin
			cfg_d = HWDATA_IN[15:0] & LPSC_FEATURE_MASK;
		end
		case (state_q)
			LPSC_ST_POWERUP: begin
				// the strap is only trusted once the synchroniser has filled
				if (settle_q != LPSC_SETTLE_CYCLES) begin
					settle_d = settle_q + 2'h1;
				end else begin
					cfg_d[LPSC_AUTO_MODE_BIT] = strap_s;
					state_d = strap_s ? LPSC_ST_NORMAL
					                  : LPSC_ST_STANDBY;
				end
			end
			LPSC_ST_STANDBY, LPSC_ST_NORMAL, LPSC_ST_SLEEP: begin
				if (cmd_q[LPSC_STBY_CMD_BIT]) begin
					state_d = LPSC_ST_STANDBY;
				end else if (cmd_q[LPSC_NORM_CMD_BIT]) begin
					state_d = LPSC_ST_NORMAL;
				end else if (state_q == LPSC_ST_STANDBY &&
				             cfg_q[LPSC_SLEEP_EN_BIT] && sleep_req_s) begin
					state_d = LPSC_ST_SLEEP;
				end else if (state_q == LPSC_ST_SLEEP &&
				             (!cfg_q[LPSC_SLEEP_EN_BIT] ||
				              (cfg_q[LPSC_ENERGY_DETECT_ENABLE_BIT] && energy_s))) begin
					// permission withdrawn or line energy wakes the device
					state_d = LPSC_ST_STANDBY;
				end
				// the transition is taken, so both command bits retire
				cmd_d = LPSC_COMMAND_RST;
			end
			default: begin
				state_d = LPSC_ST_POWERUP;
			end
		endcase
		// a new command written in the retiring cycle is not lost
		if (wr_command) begin
			cmd_d = HWDATA_IN[15:0] & LPSC_COMMAND_MASK;
		end
	end

	always_comb begin
		case (state_d)
			LPSC_ST_STANDBY: code_d = LPSC_CODE_STANDBY;
			LPSC_ST_NORMAL:  code_d = LPSC_CODE_NORMAL;
			LPSC_ST_SLEEP:   code_d = LPSC_CODE_SLEEP;
			default:         code_d = LPSC_CODE_POWERUP;
		endcase
		seen_d = cfg_d[LPSC_ENERGY_DETECT_ENABLE_BIT] && energy_s;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			state_q         <= LPSC_ST_POWERUP;
			cfg_q           <= LPSC_FEATURE_RST;
			cmd_q           <= LPSC_COMMAND_RST;
			settle_q        <= 2'h0;
			PWR_STATE_OUT   <= LPSC_CODE_POWERUP;
			SLEEP_OUT       <= 1'b0;
			ED_ENABLE_OUT   <= 1'b0;
			ENERGY_SEEN_OUT <= 1'b0;
		end else begin
			state_q         <= state_d;
			cfg_q           <= cfg_d;
			cmd_q           <= cmd_d;
			settle_q        <= settle_d;
			PWR_STATE_OUT   <= code_d;
			SLEEP_OUT       <= (state_d == LPSC_ST_SLEEP);
			ED_ENABLE_OUT   <= cfg_d[LPSC_ENERGY_DETECT_ENABLE_BIT];
			ENERGY_SEEN_OUT <= seen_d;
		end
	end

	// -------------------------------------------------------------------
	// ahb-lite data phase: zero wait states, reads see next-state values
	// -------------------------------------------------------------------
	logic [31:0] rdata_d;

	always_comb begin
		rdata_d = 32'h00000000;
		if (addr_valid && !HWRITE_IN) begin
			case (HADDR_IN)
				LPSC_ADDR_FEATURE: rdata_d = {16'h0000, cfg_d};
				LPSC_ADDR_COMMAND: rdata_d = {16'h0000, cmd_d};
				LPSC_ADDR_STATUS:  rdata_d = {25'h0000000, code_d};
				default:           rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			HRDATA_OUT    <= 32'h00000000;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT     <= 1'b0;
		end else begin
			HRDATA_OUT    <= rdata_d;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT     <= 1'b0;
		end
	end

	// -------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	logic running;
	assign running = (state_q != LPSC_ST_POWERUP);

	a_detect_gated: assert property (
		ENERGY_SEEN_OUT |-> ED_ENABLE_OUT && $past(energy_s))
		else $error("energy seen while detection disabled");

	a_sleep_entry_permit: assert property (
		$rose(SLEEP_OUT) |-> $past(cfg_q[LPSC_SLEEP_EN_BIT]) &&
		                     $past(state_q) == LPSC_ST_STANDBY)
		else $error("sleep entered without permission");

	a_sleep_leave_forbid: assert property (
		state_q == LPSC_ST_SLEEP && !cfg_q[LPSC_SLEEP_EN_BIT] &&
		!wr_feature |=> !SLEEP_OUT)
		else $error("stayed asleep after permission cleared");

	a_powerup_target: assert property (
		$past(state_q) == LPSC_ST_POWERUP && running |->
		(state_q == LPSC_ST_NORMAL) == cfg_q[LPSC_AUTO_MODE_BIT])
		else $error("wrong state after power-up");

	a_standby_cmd: assert property (
		running && cmd_q[LPSC_STBY_CMD_BIT] && !wr_command |=>
		state_q == LPSC_ST_STANDBY && !cmd_q[LPSC_STBY_CMD_BIT])
		else $error("standby command not honoured");

	a_normal_cmd: assert property (
		running && cmd_q == 16'h0001 && !wr_command |=>
		state_q == LPSC_ST_NORMAL ##0 cmd_q == 16'h0000)
		else $error("normal command not honoured");

	a_status_code: assert property (
		(state_q == LPSC_ST_STANDBY |-> PWR_STATE_OUT == 7'h02) and
		(state_q == LPSC_ST_NORMAL  |-> PWR_STATE_OUT == 7'h04))
		else $error("status code does not match state");

	a_both_cmd_standby: assert property (
		running && cmd_q == 16'h0011 && !wr_command |=>
		cmd_q == 16'h0000 && PWR_STATE_OUT == 7'h02)
		else $error("double command did not pick standby");

	c_powerup_normal: cover property (
		$past(state_q) == LPSC_ST_POWERUP && state_q == LPSC_ST_NORMAL);
	c_sleep_wake: cover property (
		state_q == LPSC_ST_SLEEP ##1 state_q == LPSC_ST_STANDBY);
	c_both_cmd: cover property (running && cmd_q == 16'h0011);

	a_sleep_forbid: assert property (
		state_q != LPSC_ST_SLEEP && !cfg_q[LPSC_SLEEP_EN_BIT] |=>
		state_q != LPSC_ST_SLEEP)
		else $error("slept while sleep not permitted");

	a_detect_off_quiet: assert property (
		!ED_ENABLE_OUT |-> !ENERGY_SEEN_OUT)
		else $error("energy reported with detection off");

	a_cmd_self_clear: assert property (
		running && cmd_q != 16'h0000 && !wr_command |=>
		cmd_q == 16'h0000)
		else $error("command bit did not clear");

	a_wake_on_energy: assert property (
		state_q == LPSC_ST_SLEEP && cmd_q == 16'h0000 &&
		cfg_q[LPSC_ENERGY_DETECT_ENABLE_BIT] && energy_s |=>
		state_q == LPSC_ST_STANDBY)
		else $error("line energy did not wake the device");

	a_no_wake_unarmed: assert property (
		state_q == LPSC_ST_SLEEP && cmd_q == 16'h0000 &&
		cfg_q[LPSC_SLEEP_EN_BIT] && !cfg_q[LPSC_ENERGY_DETECT_ENABLE_BIT] |=>
		state_q == LPSC_ST_SLEEP)
		else $error("woke from sleep with detection off");

	c_energy_wake: cover property (
		state_q == LPSC_ST_SLEEP && energy_s ##1
		state_q == LPSC_ST_STANDBY);
	c_cmd_standby: cover property (
		state_q == LPSC_ST_NORMAL ##1 state_q == LPSC_ST_STANDBY);

endmodule

`default_nettype wire

// >>> common/lpsc_pkg.sv
// constants and types for the low-power state control block
`default_nettype none

package lpsc_pkg;

	// -------------------------------------------------------------------
	// register indices (byte address is four times the index)
	// -------------------------------------------------------------------
	localparam logic [9:0]  LPSC_IDX_FEATURE = 10'h18b;
	localparam logic [9:0]  LPSC_IDX_COMMAND = 10'h18c;
	localparam logic [9:0]  LPSC_IDX_STATUS  = 10'h18e;
	localparam logic [31:0] LPSC_ADDR_FEATURE = {20'h00000, LPSC_IDX_FEATURE,
	                                             2'b00};
	localparam logic [31:0] LPSC_ADDR_COMMAND = {20'h00000, LPSC_IDX_COMMAND,
	                                             2'b00};
	localparam logic [31:0] LPSC_ADDR_STATUS  = {20'h00000, LPSC_IDX_STATUS,
	                                             2'b00};

	// -------------------------------------------------------------------
	// field positions, masks and reset values
	// -------------------------------------------------------------------
	localparam int          LPSC_ENERGY_DETECT_ENABLE_BIT     = 8;
	localparam int          LPSC_SLEEP_EN_BIT  = 7;
	localparam int          LPSC_AUTO_MODE_BIT = 6;
	localparam int          LPSC_STBY_CMD_BIT  = 4;
	localparam int          LPSC_NORM_CMD_BIT  = 0;
	localparam logic [15:0] LPSC_FEATURE_MASK  = 16'h01c0;
	localparam logic [15:0] LPSC_COMMAND_MASK  = 16'h0011;
	localparam logic [15:0] LPSC_FEATURE_RST   = 16'h0000;
	localparam logic [15:0] LPSC_COMMAND_RST   = 16'h0000;
	localparam int          LPSC_CODE_W        = 7;

	// -------------------------------------------------------------------
	// power state codes as reported in the status field
	// -------------------------------------------------------------------
	localparam logic [6:0]  LPSC_CODE_POWERUP = 7'h00;
	localparam logic [6:0]  LPSC_CODE_SLEEP   = 7'h01;
	localparam logic [6:0]  LPSC_CODE_STANDBY = 7'h02;
	localparam logic [6:0]  LPSC_CODE_NORMAL  = 7'h04;

	// -------------------------------------------------------------------
	// bus and timing constants
	// -------------------------------------------------------------------
	localparam logic [1:0]  LPSC_HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0]  LPSC_SETTLE_CYCLES = 2'h3;

	typedef enum logic [1:0] {
		LPSC_ST_POWERUP = 2'b00,
		LPSC_ST_STANDBY = 2'b01,
		LPSC_ST_NORMAL  = 2'b10,
		LPSC_ST_SLEEP   = 2'b11
	} lpsc_state_t;

endpackage

`default_nettype wire

// >>> dv/lpsc_tb_top.sv
// self-checking bench for the low-power state control block
`default_nettype none

module lpsc_tb_top
	import lpsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// -------------------------------------------------------------------
	// signals
	// -------------------------------------------------------------------
	logic        clk_in;
	logic        rst_n_in;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        strap;
	logic        energy;
	logic        sleep_req;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic [6:0]  pwr_state;
	logic        sleep_o;
	logic        energy_detect_enable_o;
	logic        energy_seen;
	int          n_fail;
	int          n_compared;

	lpsc_top dut (
		.CLK_IN(clk_in), .RST_N_IN(rst_n_in), .HSEL_IN(hsel),
		.HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
		.HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
		.AUTO_STRAP_IN(strap), .ENERGY_IN(energy),
		.SLEEP_REQ_IN(sleep_req), .HRDATA_OUT(hrdata),
		.HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
		.PWR_STATE_OUT(pwr_state), .SLEEP_OUT(sleep_o),
		.ED_ENABLE_OUT(energy_detect_enable_o), .ENERGY_SEEN_OUT(energy_seen)
	);

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// -------------------------------------------------------------------
	// report, compare and bus tasks
	// -------------------------------------------------------------------
	task automatic end_of_test();
		if (n_fail == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// slave may stretch a phase; a bound keeps a dead bus from hanging us
	task automatic wait_rdy();
		int i;
		i = 0;
		do begin
			@(posedge clk_in);
			i++;
		end while (hready !== 1'b1 && i < 100);
		if (hready !== 1'b1) begin
			n_fail++;
			end_of_test();
		end
	endtask

	task automatic xfer(input logic [31:0] a, input logic w,
	                    input logic [31:0] d, output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= LPSC_HTRANS_NONSEQ;
		hwrite <= w;
		hsize  <= 3'h2;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0000_0000;
		wait_rdy();
		rd = hrdata;
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] unused;
		xfer(a, 1'b1, d, unused);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] v;
		xfer(a, 1'b0, 32'h0000_0000, v);
		chk(v, exp);
	endtask

	// strap is sampled after release, so it must be set before this
	task automatic do_reset();
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (10) @(posedge clk_in);
	endtask

	// -------------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------------
	initial begin
		n_fail = 0;
		n_compared = 0;
		rst_n_in = 1'b0;
		{hsel, hwrite, strap, energy, sleep_req} = 5'h00;
		{haddr, hwdata} = 64'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		do_reset();
		chk({25'h0, pwr_state}, {25'h0, LPSC_CODE_STANDBY});
		rd_chk(LPSC_ADDR_FEATURE, 32'h0000_0000);
		rd_chk(LPSC_ADDR_COMMAND, 32'h0000_0000);
		rd_chk(LPSC_ADDR_STATUS, 32'h0000_0002);
		chk({31'h0, energy_detect_enable_o}, 32'h0000_0000);
		wr(32'h0000_0100, 32'hffff_ffff);
		rd_chk(32'h0000_0100, 32'h0000_0000);
		wr(LPSC_ADDR_STATUS, 32'hffff_ffff);
		rd_chk(LPSC_ADDR_STATUS, 32'h0000_0002);
		wr(LPSC_ADDR_COMMAND, 32'h0000_0001);
		rd_chk(LPSC_ADDR_COMMAND, 32'h0000_0000);
		rd_chk(LPSC_ADDR_STATUS, 32'h0000_0004);
		chk({25'h0, pwr_state}, 32'h0000_0004);
		wr(LPSC_ADDR_COMMAND, 32'h0000_0010);
		rd_chk(LPSC_ADDR_COMMAND, 32'h0000_0000);
		rd_chk(LPSC_ADDR_STATUS, 32'h0000_0002);
		wr(LPSC_ADDR_COMMAND, 32'h0000_0001);
		rd_chk(LPSC_ADDR_STATUS, 32'h0000_0004);
		wr(LPSC_ADDR_COMMAND, 32'h0000_0011);
		rd_chk(LPSC_ADDR_COMMAND, 32'h0000_0000);
		rd_chk(LPSC_ADDR_STATUS, 32'h0000_0002);
		// energy present but detection off must stay invisible
		energy <= 1'b1;
		repeat (6) @(posedge clk_in);
		chk({31'h0, energy_seen}, 32'h0000_0000);
		wr(LPSC_ADDR_FEATURE, 32'h0000_0100);
		rd_chk(LPSC_ADDR_FEATURE, 32'h0000_0100);
		repeat (6) @(posedge clk_in);
		chk({30'h0, energy_detect_enable_o, energy_seen}, 32'h0000_0003);
		wr(LPSC_ADDR_FEATURE, 32'h0000_0000);
		repeat (6) @(posedge clk_in);
		chk({30'h0, energy_detect_enable_o, energy_seen}, 32'h0000_0000);
		energy <= 1'b0;
		sleep_req <= 1'b1;
		repeat (6) @(posedge clk_in);
		chk({31'h0, sleep_o}, 32'h0000_0000);
		rd_chk(LPSC_ADDR_STATUS, 32'h0000_0002);
		wr(LPSC_ADDR_FEATURE, 32'h0000_0080);
		repeat (6) @(posedge clk_in);
		chk({31'h0, sleep_o}, 32'h0000_0001);
		rd_chk(LPSC_ADDR_STATUS, {25'h0, LPSC_CODE_SLEEP});
		wr(LPSC_ADDR_FEATURE, 32'h0000_0000);
		repeat (6) @(posedge clk_in);
		chk({31'h0, sleep_o}, 32'h0000_0000);
		rd_chk(LPSC_ADDR_STATUS, 32'h0000_0002);
		// sleep again with detection on; the request drops so a wake sticks
		wr(LPSC_ADDR_FEATURE, 32'h0000_0180);
		repeat (6) @(posedge clk_in);
		chk({31'h0, sleep_o}, 32'h0000_0001);
		sleep_req <= 1'b0;
		repeat (6) @(posedge clk_in);
		chk({31'h0, sleep_o}, 32'h0000_0001);
		energy <= 1'b1;
		repeat (6) @(posedge clk_in);
		chk({30'h0, sleep_o, energy_seen}, 32'h0000_0001);
		rd_chk(LPSC_ADDR_STATUS, 32'h0000_0002);
		energy <= 1'b0;
		wr(LPSC_ADDR_FEATURE, 32'hffff_ffff);
		rd_chk(LPSC_ADDR_FEATURE, 32'h0000_01c0);
		wr(LPSC_ADDR_FEATURE, 32'h0000_0000);
		strap <= 1'b1;
		do_reset();
		rd_chk(LPSC_ADDR_STATUS, 32'h0000_0004);
		rd_chk(LPSC_ADDR_FEATURE, 32'h0000_0040);
		end_of_test();
	end

endmodule

`default_nettype wire
